// *** common/flash_host_pkg.sv ***
// Constants, types and register map of the parallel NOR flash host.
// Assumes one 20 MHz clock and a flash part with word-wide data.
package flash_host_pkg;

   // Clock rate and bus-cycle timing, each count derived from its time.
   localparam int CLK_MHZ = 20;
   localparam int T_STROBE_NS = 100;
   localparam int T_RECOVER_NS = 50;
   localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVER_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;

   // Flash pin widths.
   localparam int ADDR_W = 19;
   localparam int DATA_W = 16;

   // APB register offsets.
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;

   // Status register field positions.
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_READY = 3;
   localparam int ST_POLL_OK = 4;

   // Reset values.
   localparam logic [18:0] ADDR_RST = 19'h00000;
   localparam logic [15:0] DATA_RST = 16'h0000;

   // Command-cycle addresses and values.
   localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
   localparam logic [18:0] UNLOCK2_ADDR = 19'h002AA;
   localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
   localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
   localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
   localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
   localparam logic [15:0] CMD_RESET = 16'h00F0;
   localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
   localparam logic [15:0] CMD_RESUME = 16'h0030;
   localparam logic [15:0] CMD_IDENT = 16'h0090;
   localparam int SECTOR_LSB = 12;

   // Status bit positions on the data pins.
   localparam int POLL_BIT = 7;
   localparam int TOGGLE1_BIT = 6;
   localparam int FAIL_BIT = 5;
   localparam int ETIMER_BIT = 3;
   localparam int TOGGLE2_BIT = 2;

   // Operations software can order through the command register.
   typedef enum logic [3:0] {
      OP_READ, OP_RESET, OP_PROGRAM, OP_CHIP_ERASE,
      OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_IDENT
   } op_e;
   localparam logic [3:0] OP_LAST = 4'h7;

   // Flash-side pins driven by the host.
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [18:0] addr;
      logic [15:0] dq_o;
      logic dq_oe;
   } flash_pins_s;

   // One bus cycle to run on the flash pins.
   typedef struct packed {
      logic wr;
      logic [18:0] addr;
      logic [15:0] data;
   } bus_cyc_s;

endpackage

// *** rtl/flash_cycle.sv ***
// Runs one read or write bus cycle on the flash pins.
// Assumes the data pins are synchronous to pclk and a start only when idle.
`timescale 1ns/1ps
`default_nettype none
module flash_cycle (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire flash_host_pkg::bus_cyc_s req,
   input wire logic [15:0] dq_i,
   output flash_host_pkg::flash_pins_s pins,
   output logic [15:0] rdata,
   output logic done
);
   typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_RECOV} cst_e;
   cst_e st_r;
   logic [3:0] cnt_r;
   logic wr_r;
   logic strobe_end;

   // Last cycle of the strobe; the recovery end is compared in C_RECOV.
   assign strobe_end = (cnt_r == 4'(flash_host_pkg::STROBE_CYC - 1));

   // Cycle sequencer: address set-up, strobe, hold, recovery.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= C_IDLE;
         cnt_r <= 4'h0;
         wr_r <= 1'b0;
         pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 19'h00000,
                   dq_o: 16'h0000, dq_oe: 1'b0};
         rdata <= 16'h0000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         cnt_r <= cnt_r + 4'h1;
         case (st_r)
            C_IDLE: begin
               if (start) begin
                  st_r <= C_SETUP;
                  wr_r <= req.wr;
                  pins.ce_n <= 1'b0;
                  pins.addr <= req.addr;
                  pins.dq_o <= req.data;
                  pins.dq_oe <= req.wr;
               end
            end
            C_SETUP: begin
               st_r <= C_STROBE;
               cnt_r <= 4'h0;
               pins.we_n <= ~wr_r; // Strobe with gate off.
               pins.oe_n <= wr_r;
            end
            C_STROBE: begin
               if (strobe_end) begin
                  st_r <= C_HOLD;
                  pins.we_n <= 1'b1;
                  pins.oe_n <= 1'b1;
                  if (!wr_r) begin
                     rdata <= dq_i;
                  end
               end
            end
            C_HOLD: begin
               st_r <= C_RECOV;
               cnt_r <= 4'h0;
               pins.ce_n <= 1'b1;
               pins.dq_oe <= 1'b0;
               done <= 1'b1;
            end
            C_RECOV: begin
               if (cnt_r == 4'(flash_host_pkg::RECOVER_CYC - 1)) begin
                  st_r <= C_IDLE;
               end
            end
            default: st_r <= C_IDLE;
         endcase
      end
   end

   // Write and output-gate strobes never overlap.
   AST_WRITE_NO_OE: assert property (@(posedge pclk)
      disable iff (!presetn)
      !pins.we_n |-> pins.oe_n)
      else $error("Write strobe low while output gate low.");

   // The write strobe lasts exactly the strobe time.
   AST_STROBE_LEN: assert property (@(posedge pclk)
      disable iff (!presetn)
      $fell(pins.we_n) |-> !pins.we_n [*2] ##1 pins.we_n)
      else $error("Write strobe width wrong.");

   // Data is driven through the whole write strobe with chip select low.
   AST_DQ_DRIVE: assert property (@(posedge pclk)
      disable iff (!presetn)
      !pins.we_n |-> pins.dq_oe && !pins.ce_n)
      else $error("Write strobe without driven data.");

endmodule
`default_nettype wire

// *** rtl/flash_host.sv ***
// Host controller for a parallel NOR flash, ordered over APB.
// Assumes the flash pins are synchronous to pclk and pready never waits.
`timescale 1ns/1ps
`default_nettype none
module flash_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output flash_host_pkg::flash_pins_s pins,
   input wire logic [15:0] dq_i,
   input wire logic ready_busy_out
);
   typedef enum logic [2:0] {S_IDLE, S_SEQ, S_POLL, S_FAILRST} st_e;

   st_e st_r;
   flash_host_pkg::op_e op_r;
   logic [18:0] addr_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic [15:0] prev_r;
   logic [2:0] idx_r;
   logic wait_r;
   logic first_r;
   logic recheck_r;
   logic done_r;
   logic fail_r;
   logic poll_ok_r;
   logic [7:0] poll_reads_r;
   logic cyc_start;
   logic cyc_done;
   logic [15:0] cyc_rdata;
   flash_host_pkg::bus_cyc_s cyc_req;

   // Bus cycle for one step of a command sequence.
   function automatic flash_host_pkg::bus_cyc_s step_of(
      input flash_host_pkg::op_e op, input logic [2:0] idx,
      input logic [18:0] a, input logic [15:0] d);
      flash_host_pkg::bus_cyc_s c;
      logic [18:0] sa;
      c = '{wr: 1'b1, addr: flash_host_pkg::UNLOCK1_ADDR,
            data: flash_host_pkg::UNLOCK1_DATA};
      sa = {a[18:flash_host_pkg::SECTOR_LSB], 12'h000}; // Sector select.
      if (idx == 3'd1 || idx == 3'd4) begin
         c.addr = flash_host_pkg::UNLOCK2_ADDR;
         c.data = flash_host_pkg::UNLOCK2_DATA;
      end
      case (op)
         flash_host_pkg::OP_READ: c = '{wr: 1'b0, addr: a, data: d};
         flash_host_pkg::OP_RESET: c.data = flash_host_pkg::CMD_RESET;
         flash_host_pkg::OP_SUSPEND: c.data = flash_host_pkg::CMD_SUSPEND;
         flash_host_pkg::OP_RESUME: c.data = flash_host_pkg::CMD_RESUME;
         flash_host_pkg::OP_PROGRAM: begin
            if (idx == 3'd2) begin
               c.data = flash_host_pkg::CMD_PROGRAM;
            end else if (idx == 3'd3) begin
               c.addr = a;
               c.data = d;
            end
         end
         flash_host_pkg::OP_IDENT: begin
            if (idx == 3'd2) begin
               c.data = flash_host_pkg::CMD_IDENT;
            end else if (idx == 3'd3) begin
               c = '{wr: 1'b0, addr: a, data: d}; // Fourth cycle reads.
            end
         end
         default: begin
            if (idx == 3'd2) begin
               c.data = flash_host_pkg::CMD_ERASE_SETUP;
            end else if (idx == 3'd5) begin
               if (op == flash_host_pkg::OP_SECTOR_ERASE) begin
                  c.addr = sa;
                  c.data = flash_host_pkg::CMD_SECTOR_ERASE;
               end else begin
                  c.data = flash_host_pkg::CMD_CHIP_ERASE;
               end
            end
         end
      endcase
      return c;
   endfunction

   // APB decode; writes take effect at the access edge, no wait states.
   wire acc = psel && penable;
   wire wr_cmd = acc && pwrite && paddr == flash_host_pkg::REG_CMD;
   wire wr_addr = acc && pwrite && paddr == flash_host_pkg::REG_ADDR;
   wire wr_wdata = acc && pwrite && paddr == flash_host_pkg::REG_WDATA;
   wire mapped = paddr == flash_host_pkg::REG_CMD
      || paddr == flash_host_pkg::REG_ADDR
      || paddr == flash_host_pkg::REG_WDATA
      || paddr == flash_host_pkg::REG_STATUS
      || paddr == flash_host_pkg::REG_RDATA;
   wire busy = st_r != S_IDLE;
   wire cmd_go = wr_cmd && !busy && pwdata[3:0] <= flash_host_pkg::OP_LAST;
   wire poll_op = op_r == flash_host_pkg::OP_PROGRAM
      || op_r == flash_host_pkg::OP_CHIP_ERASE
      || op_r == flash_host_pkg::OP_SECTOR_ERASE;
   wire [2:0] last_idx = (op_r == flash_host_pkg::OP_PROGRAM
      || op_r == flash_host_pkg::OP_IDENT) ? 3'd3 : poll_op ? 3'd5 : 3'd0;
   wire toggled = prev_r[flash_host_pkg::TOGGLE1_BIT]
      ^ cyc_rdata[flash_host_pkg::TOGGLE1_BIT];
   wire [15:0] expect_v = (op_r == flash_host_pkg::OP_PROGRAM) ?
      wdata_r : 16'hFFFF;
   wire poll_match = cyc_rdata[flash_host_pkg::POLL_BIT]
      == expect_v[flash_host_pkg::POLL_BIT];
   wire poll_bad = recheck_r && !poll_match;
   wire [31:0] status_w = {27'h0000000, poll_ok_r, ready_busy_out,
      fail_r, done_r, busy};

   assign pready = 1'b1;
   assign pslverr = acc && !mapped;

   // Read data mux; unmapped offsets read as zero.
   always_comb begin
      case (paddr)
         flash_host_pkg::REG_CMD: prdata = {28'h0000000, op_r};
         flash_host_pkg::REG_ADDR: prdata = {13'h0000, addr_r};
         flash_host_pkg::REG_WDATA: prdata = {16'h0000, wdata_r};
         flash_host_pkg::REG_STATUS: prdata = status_w;
         flash_host_pkg::REG_RDATA: prdata = {16'h0000, rdata_r};
         default: prdata = 32'h00000000;
      endcase
   end

   // Cycle request: sequence step, status read at the poll address, or reset.
   assign cyc_start = busy && !wait_r;
   always_comb begin
      case (st_r)
         S_POLL: cyc_req = '{wr: 1'b0, addr: addr_r, data: wdata_r};
         S_FAILRST: cyc_req = '{wr: 1'b1, addr: flash_host_pkg::UNLOCK1_ADDR,
                                data: flash_host_pkg::CMD_RESET};
         default: cyc_req = step_of(op_r, idx_r, addr_r, wdata_r);
      endcase
   end

   flash_cycle u_cycle (
      .pclk(pclk),
      .presetn(presetn),
      .start(cyc_start),
      .req(cyc_req),
      .dq_i(dq_i),
      .pins(pins),
      .rdata(cyc_rdata),
      .done(cyc_done)
   );

   // Software-written address and data registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r <= flash_host_pkg::ADDR_RST;
         wdata_r <= flash_host_pkg::DATA_RST;
      end else begin
         if (wr_addr && !busy) begin
            addr_r <= pwdata[18:0];
         end
         if (wr_wdata && !busy) begin
            wdata_r <= pwdata[15:0];
         end
      end
   end

   // Operation sequencer with toggle-bit status polling.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= S_IDLE;
         op_r <= flash_host_pkg::OP_READ;
         idx_r <= 3'd0;
         wait_r <= 1'b0;
         first_r <= 1'b1;
         recheck_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
         poll_ok_r <= 1'b0;
         prev_r <= flash_host_pkg::DATA_RST;
         rdata_r <= flash_host_pkg::DATA_RST;
         poll_reads_r <= 8'h00;
      end else begin
         if (cyc_start) begin
            wait_r <= 1'b1;
         end
         case (st_r)
            S_IDLE: begin
               if (cmd_go) begin
                  op_r <= flash_host_pkg::op_e'(pwdata[3:0]);
                  st_r <= S_SEQ;
                  idx_r <= 3'd0;
                  done_r <= 1'b0;
                  fail_r <= 1'b0;
                  poll_ok_r <= 1'b0;
                  recheck_r <= 1'b0;
                  first_r <= 1'b1;
                  poll_reads_r <= 8'h00;
               end
            end
            S_SEQ: begin
               if (cyc_done) begin
                  wait_r <= 1'b0;
                  idx_r <= idx_r + 3'd1;
                  if (idx_r == last_idx) begin
                     // Status is valid once the last write strobe rises.
                     st_r <= poll_op ? S_POLL : S_IDLE;
                     done_r <= !poll_op;
                     if (!cyc_req.wr) begin
                        rdata_r <= cyc_rdata;
                     end
                  end
               end
            end
            S_POLL: begin
               if (cyc_done) begin
                  wait_r <= 1'b0;
                  // The count saturates so that a long erase cannot wrap it.
                  if (poll_reads_r != 8'hFF) begin
                     poll_reads_r <= poll_reads_r + 8'h01;
                  end
                  prev_r <= cyc_rdata;
                  first_r <= 1'b0;
                  // Judge toggling only on a second consecutive read.
                  if (!first_r && !toggled) begin
                     // A mismatch after a recheck ends with a reset write.
                     st_r <= poll_bad ? S_FAILRST : S_IDLE;
                     done_r <= !poll_bad;
                     poll_ok_r <= poll_match; // Final poll bit.
                     rdata_r <= cyc_rdata; // Status, not data.
                  end else if (!first_r && recheck_r) begin
                     st_r <= S_FAILRST;
                  end else if (!first_r
                               && cyc_rdata[flash_host_pkg::FAIL_BIT]) begin
                     recheck_r <= 1'b1; // Toggle may stop as fail sets.
                     first_r <= 1'b1;
                  end
               end
            end
            S_FAILRST: begin
               if (cyc_done) begin
                  wait_r <= 1'b0;
                  st_r <= S_IDLE;
                  done_r <= 1'b1;
                  fail_r <= 1'b1;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // A failed operation is always closed by a reset command write.
   AST_FAIL_RESET: assert property (@(posedge pclk)
      disable iff (!presetn)
      $rose(fail_r) |-> $past(st_r) == S_FAILRST && $past(cyc_done))
      else $error("Failure reported without reset command.");

   // The failure reset cycle writes the reset command.
   AST_RESET_CMD: assert property (@(posedge pclk)
      disable iff (!presetn)
      st_r == S_FAILRST && cyc_start |->
      cyc_req.wr && cyc_req.data == flash_host_pkg::CMD_RESET)
      else $error("Failure reset cycle is not a reset write.");

   // Identification ends with a read cycle at the requested address.
   AST_IDENT_READ: assert property (@(posedge pclk)
      disable iff (!presetn)
      op_r == flash_host_pkg::OP_IDENT && st_r == S_SEQ && idx_r == 3'd3
      && cyc_start |-> !cyc_req.wr && cyc_req.addr == addr_r)
      else $error("Fourth identification cycle is not a read.");

   // Status polls read at the program or sector address.
   AST_POLL_ADDR: assert property (@(posedge pclk)
      disable iff (!presetn)
      st_r == S_POLL && cyc_start |-> !cyc_req.wr && cyc_req.addr == addr_r)
      else $error("Status poll not a read at the operation address.");

   // Completion of a polled operation follows at least two status reads.
   AST_TWO_READS: assert property (@(posedge pclk)
      disable iff (!presetn)
      $rose(done_r) && poll_op && !fail_r |-> poll_reads_r >= 8'h02)
      else $error("Completion judged from fewer than two reads.");

   // A toggle failure is only declared after the recheck pair.
   AST_RECHECK: assert property (@(posedge pclk)
      disable iff (!presetn)
      $rose(st_r == S_FAILRST) |-> recheck_r && poll_reads_r >= 8'h04)
      else $error("Failure declared without rechecking the poll bit.");

   // Captured data changes only on a finished bus cycle.
   AST_DATA_AFTER: assert property (@(posedge pclk)
      disable iff (!presetn)
      $changed(rdata_r) |-> $past(cyc_done))
      else $error("Read data changed without a bus cycle.");

endmodule
`default_nettype wire

// *** testbench/flash_dev_model.sv ***
// Behavioural flash device that answers the host's bus cycles.
// Assumes pins change on pclk; pclk only times the internal algorithms.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter int PROG_CYC = 30,
   parameter int PROT_PROG_CYC = 40,
   parameter int ERASE_CYC = 60,
   parameter int PROT_ERASE_CYC = 2000,
   parameter logic [6:0] PROT_SEC = 7'h7E,
   parameter logic [15:0] ID_CODE = 16'h1234 // Arbitrary value.
) (
   input wire logic pclk,
   input wire flash_host_pkg::flash_pins_s pins,
   input wire logic fail_mode,
   output logic [15:0] dout,
   output logic dout_en,
   output logic rb_low
);
   logic [15:0] mem [logic [18:0]];
   logic [18:0] la, pa;
   logic [15:0] pd;
   logic [6:0] esec;
   int step = 0;
   int cnt = 0;
   bit ident, susp, chip, prun, erun, failed, nowr, tog1, tog2;
   wire logic wr_act = !pins.we_n && !pins.ce_n;
   wire logic rd_act = !pins.oe_n && !pins.ce_n;
   wire logic in_es = chip || pins.addr[18:12] == esec;

   // The open drain pulls low only while an algorithm runs.
   assign rb_low = prun || erun;

   function automatic logic [15:0] rd_mem(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction

   // Decodes one write cycle; high address bits are ignored on unlocks.
   task automatic command(input logic [18:0] a, input logic [15:0] d);
      logic u1, u2;
      u1 = a[10:0] == 11'h555;
      u2 = a[10:0] == 11'h2AA;
      if (prun || erun) begin
         if (failed && d == 16'h00F0) {prun, erun, failed} = 3'b000;
         else if (erun && !chip && d == 16'h00B0) {erun, susp} = 2'b01;
      end else if (d == 16'h00F0) begin
         ident = 0;
         step = 0;
      end else if (susp && step == 0 && d == 16'h0030) begin
         {susp, erun} = 2'b01;
      end else case (step)
         0: step = (u1 && d == 16'h00AA) ? 1 : 0;
         1: step = (u2 && d == 16'h0055) ? 2 : 0;
         2: begin
            ident = u1 && d == 16'h0090;
            step = !u1 ? 0 : d == 16'h00A0 ? 6 : d == 16'h0080 ? 3 : 0;
         end
         3: step = (u1 && d == 16'h00AA) ? 4 : 0;
         4: step = (u2 && d == 16'h0055) ? 5 : 0;
         5: begin
            chip = u1 && d == 16'h0010;
            esec = a[18:12];
            erun = chip || d == 16'h0030;
            cnt = (!chip && esec == PROT_SEC) ? PROT_ERASE_CYC : ERASE_CYC;
            step = 0;
         end
         default: begin
            pa = a;
            pd = d;
            prun = 1;
            step = 0;
            nowr = a[18:12] == PROT_SEC;
            cnt = nowr ? PROT_PROG_CYC : PROG_CYC;
         end
      endcase
   endtask

   // Address is taken when the later strobe falls, data when one rises.
   always @(posedge wr_act) la = pins.addr;
   always @(negedge wr_act) begin
      if (!$isunknown(pins.dq_o)) command(la, pins.dq_o);
   end

   // Runs the algorithm down; a forced fault freezes it with the fail bit.
   always @(posedge pclk) begin
      if ((prun || erun) && !failed) begin
         if (cnt > 0) cnt = cnt - 1;
         else if (fail_mode) failed = 1;
         else if (prun) begin
            if (!nowr) mem[pa] = rd_mem(pa) & pd;
            prun = 0;
         end else begin
            foreach (mem[k])
               if ((chip || k[18:12] == esec) && k[18:12] != PROT_SEC)
                  mem[k] = 16'hFFFF;
            erun = 0;
         end
      end
   end

   // Drives status while busy or reading the suspended sector, else ident or array data.
   always @(posedge rd_act) begin
      dout_en = 1;
      if (prun) dout = {8'h00, ~pd[7], tog1, failed, 5'h00};
      else if (erun)
         dout = {8'h00, 1'b0, tog1, failed, 2'b01, tog2 & in_es, 2'b00};
      else if (susp && in_es)
         dout = {8'h00, 1'b1, tog1, 3'b000, tog2, 2'b00};
      else if (ident)
         dout = pins.addr[7:0] == 8'h02 ?
            {15'h0000, pins.addr[18:12] == PROT_SEC} : ID_CODE;
      else dout = rd_mem(pins.addr);
   end

   // Toggle bits flip as each read cycle ends while busy; the second only while erasing or suspended, in the erase sector.
   always @(negedge rd_act) begin
      dout_en = 0;
      if (prun || erun) tog1 = !tog1;
      if ((erun || susp) && in_es) tog2 = !tog2;
   end
endmodule
`default_nettype wire

// *** testbench/flash_write_status_bench.sv ***
// Self-checking bench: APB tasks order the host, a flash model answers.
// Assumes flash_host_pkg and flash_dev_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module flash_write_status_bench;
   logic pclk = 0;
   logic presetn = 0;
   logic [7:0] paddr = 8'h00;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, v;
   logic pready, pslverr, dev_en, rb_low, err;
   logic fail_mode = 0;
   logic [15:0] dq_i, dev_dq;
   logic [15:0] last_dq = 16'h0000;
   flash_host_pkg::flash_pins_s pins;
   int fail_count = 0;
   int n_tests = 0;

   always #25 pclk = ~pclk;
   // Released data pins show the inverse of their last level.
   assign dq_i = pins.dq_oe ? pins.dq_o : dev_en ? dev_dq : ~last_dq;
   always @(posedge pclk) last_dq <= dq_i;

   flash_host uut(.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
      .dq_i(dq_i), .ready_busy_out(~rb_low));
   flash_dev_model dev(.pclk(pclk), .pins(pins), .fail_mode(fail_mode),
      .dout(dev_dq), .dout_en(dev_en), .rb_low(rb_low));

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic e);
      int i;
      @(posedge pclk);
      psel <= 1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (i == 50) begin
         fail_count++;
         print_verdict();
      end
   endtask

   // Orders one operation and polls status until busy clears.
   task automatic op(input logic [3:0] o, input logic [18:0] a,
      input logic [15:0] d, output logic [31:0] s);
      logic e;
      int i;
      apb(1, flash_host_pkg::REG_ADDR, {13'h0000, a}, s, e);
      apb(1, flash_host_pkg::REG_WDATA, {16'h0000, d}, s, e);
      apb(1, flash_host_pkg::REG_CMD, {28'h0000000, o}, s, e);
      for (i = 0; i < 4000; i++) begin
         apb(0, flash_host_pkg::REG_STATUS, 32'h00000000, s, e);
         if (s[flash_host_pkg::ST_BUSY] === 1'b0) break;
      end
      if (i == 4000) begin
         fail_count++;
         print_verdict();
      end
   endtask

   // Runs one operation and compares all five status bits.
   task automatic st(input logic [3:0] o, input logic [18:0] a,
      input logic [15:0] d, input logic [31:0] exp);
      op(o, a, d, v);
      chk("status", exp, {27'h0000000, v[4:0]});
   endtask

   task automatic run_rd(input logic [3:0] o, input logic [18:0] a,
      input logic [31:0] exp);
      op(o, a, 16'h0000, v);
      apb(0, flash_host_pkg::REG_RDATA, 32'h00000000, v, err);
      chk("rdata", exp, v);
   endtask

   // Main sequence of operations with their expected results.
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      run_rd(flash_host_pkg::OP_READ, 19'h12345, 32'hFFFF);
      st(flash_host_pkg::OP_PROGRAM, 19'h12345,
         16'h5A3C, 32'h1A);
      run_rd(flash_host_pkg::OP_READ, 19'h12345, 32'h5A3C);
      st(flash_host_pkg::OP_PROGRAM, 19'h7E001, 16'h0000, 32'h0A);
      run_rd(flash_host_pkg::OP_READ, 19'h7E001, 32'hFFFF);
      run_rd(flash_host_pkg::OP_IDENT, 19'h7E002, 32'h0001);
      run_rd(flash_host_pkg::OP_IDENT, 19'h12002, 32'h0000);
      op(flash_host_pkg::OP_RESET, 19'h00000, 16'h0000, v);
      st(flash_host_pkg::OP_SUSPEND, 19'h00000, 16'h0000, 32'h0A);
      op(flash_host_pkg::OP_RESUME, 19'h00000, 16'h0000, v);
      run_rd(flash_host_pkg::OP_READ, 19'h12345, 32'h5A3C);
      st(flash_host_pkg::OP_SECTOR_ERASE, 19'h12345,
         16'h0000, 32'h1A);
      run_rd(flash_host_pkg::OP_READ, 19'h12345, 32'hFFFF);
      st(flash_host_pkg::OP_SECTOR_ERASE, 19'h7E001,
         16'h0000, 32'h1A);
      st(flash_host_pkg::OP_PROGRAM, 19'h00030, 16'h0F0F, 32'h1A);
      st(flash_host_pkg::OP_CHIP_ERASE, 19'h00030, 16'h0000, 32'h1A);
      run_rd(flash_host_pkg::OP_READ, 19'h00030, 32'hFFFF);
      fail_mode <= 1;
      st(flash_host_pkg::OP_PROGRAM, 19'h00010,
         16'h1234, 32'h0E);
      fail_mode <= 0;
      run_rd(flash_host_pkg::OP_READ, 19'h00010, 32'hFFFF);
      apb(0, 8'h40, 32'h00000000, v, err);
      chk("pslverr", 32'h1, {31'h0, err});
      chk("unmapped", 32'h0, v);
      print_verdict();
   end
endmodule
`default_nettype wire
